// ==== core/fmrp_read_path.sv ====
module fmrp_read_path #(
    parameter int ADDR_W = 24
) (
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              sck_in,
    input  wire logic              cs_n_in,
    input  wire logic [3:0]        io_lane_in,
    output logic      [3:0]        io_lane_out,
    output logic      [3:0]        io_drive_n_out,
    input  wire logic              quad_lane_enable_bit_in,
    input  wire logic              four_line_command_mode_in,
    input  wire logic              wrap_load_in,
    input  wire logic              wrap_on_in,
    input  wire logic [1:0]        wrap_size_in,
    input  wire logic              param_load_in,
    input  wire logic [1:0]        dummy_sel_in,
    input  wire logic              soft_reset_in,
    input  wire logic              mode_reset_in,
    output logic      [ADDR_W-1:0] mem_addr_out,
    input  wire logic [7:0]        mem_data_in,
    output logic                   dual_cont_out,
    output logic                   quad_cont_out,
    output logic                   wrap_on_out,
    output logic      [1:0]        dummy_sel_out
);
    import fmrp_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 12 || ADDR_W > 28 || (ADDR_W % 4) != 0) begin : g_chk
        $error("ADDR_W must be a multiple of 4 from 12 to 28");
    end

    localparam logic [4:0] ADDR_CLKS_1 = 5'(ADDR_W);
    localparam logic [4:0] ADDR_CLKS_2 = 5'(ADDR_W / 2);
    localparam logic [4:0] ADDR_CLKS_4 = 5'(ADDR_W / 4);

    typedef struct packed {
        logic              sck_s1;
        logic              sck_s2;
        logic              sck_s3;
        logic              cs_s1;
        logic              cs_s2;
        logic [3:0]        io_s1;
        logic [3:0]        io_s2;
        fmrp_state_type    st;
        fmrp_op_type       op;
        logic [4:0]        cnt;
        logic [ADDR_W-1:0] sin;
        logic [7:0]        sout;
        logic [2:0]        chunk;
        logic [ADDR_W-1:0] addr;
        logic              cont_dual;
        logic              cont_quad;
        logic              wrap_on;
        logic [1:0]        wrap_size;
        logic [1:0]        dummy_sel;
        logic [3:0]        io_out;
        logic [3:0]        io_drive_n;
    } fmrp_regs_type;

    fmrp_regs_type r;
    fmrp_regs_type next_r;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    logic              rise;
    logic              fall;
    logic              four_line_command_mode;
    logic [2:0]        lanes;
    logic [4:0]        plen;
    logic [4:0]        dlen;
    logic              pend;
    logic [ADDR_W-1:0] shifted;
    logic [7:0]        wmask;
    logic              wrap_act;
    logic [ADDR_W-1:0] addr_inc;
    logic [7:0]        low_inc;

    assign rise  = r.sck_s2 & ~r.sck_s3 & ~r.cs_s2;
    assign fall  = ~r.sck_s2 & r.sck_s3 & ~r.cs_s2;
    assign four_line_command_mode   = four_line_command_mode_in;
    assign pend  = rise && (5'(r.cnt + 5'h01) == plen);

    // Lanes in use for the current phase
    always_comb begin
        if (r.st == ST_CMD) begin
            lanes = four_line_command_mode ? 3'h4 : 3'h1;
        end else if (r.st == ST_DATA) begin
            lanes = r.op[0] ? 3'h4 : 3'h2;
        end else begin
            case (r.op)
                OP_DUAL_IO: lanes = 3'h2;
                OP_QUAD_IO: lanes = 3'h4;
                default:    lanes = 3'h1;
            endcase
        end
    end

    // Dummy clocks left after the mode byte or address
    always_comb begin
        if (r.op == OP_QUAD_IO && four_line_command_mode) begin
            case (r.dummy_sel)
                2'h0:    dlen = 5'(QPI_DUMMY_4 - QUAD_MODE);
                2'h1:    dlen = 5'(QPI_DUMMY_6 - QUAD_MODE);
                default: dlen = 5'(QPI_DUMMY_8 - QUAD_MODE);
            endcase
        end else begin
            case (r.op)
                OP_QUAD_IO: dlen = QUAD_DUMMY;
                OP_DUAL_IO: dlen = 5'h00;
                default:    dlen = OUT_DUMMY;
            endcase
        end
    end

    // Length of the current phase
    always_comb begin
        case (r.st)
            ST_CMD:  plen = four_line_command_mode ? CMD_CLKS_4 : CMD_CLKS_1;
            ST_ADDR: plen = (lanes == 3'h4) ? ADDR_CLKS_4 :
                            (lanes == 3'h2) ? ADDR_CLKS_2 : ADDR_CLKS_1;
            ST_MODE: plen = (r.op == OP_QUAD_IO) ? QUAD_MODE : DUAL_MODE;
            ST_DUMMY: plen = dlen;
            default: plen = 5'h00;
        endcase
    end

    // Input shift, lane 3 is the most significant
    always_comb begin
        case (lanes)
            3'h1:    shifted = {r.sin[ADDR_W-2:0], r.io_s2[0]};
            3'h2:    shifted = {r.sin[ADDR_W-3:0], r.io_s2[1:0]};
            default: shifted = {r.sin[ADDR_W-5:0], r.io_s2[3:0]};
        endcase
    end

    // Next read address, wrapped inside a section when enabled on quad I/O reads outside four-line command mode
    always_comb begin
        case (r.wrap_size)
            2'h0:    wmask = WRAP_MASK_8;
            2'h1:    wmask = WRAP_MASK_16;
            2'h2:    wmask = WRAP_MASK_32;
            default: wmask = WRAP_MASK_64;
        endcase
        wrap_act = r.wrap_on && r.op == OP_QUAD_IO && !four_line_command_mode;
        low_inc  = 8'(r.addr[7:0] + 8'h01);
        if (wrap_act) begin
            addr_inc = {r.addr[ADDR_W-1:8],
                        (r.addr[7:0] & ~wmask) | (low_inc & wmask)};
        end else begin
            addr_inc = ADDR_W'(r.addr + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r        = r;
        next_r.sck_s1 = sck_in;
        next_r.sck_s2 = r.sck_s1;
        next_r.sck_s3 = r.sck_s2;
        next_r.cs_s1  = cs_n_in;
        next_r.cs_s2  = r.cs_s1;
        next_r.io_s1  = io_lane_in;
        next_r.io_s2  = r.io_s1;

        // Configuration loads from the command decoder
        if (wrap_load_in) begin
            next_r.wrap_on   = wrap_on_in;
            next_r.wrap_size = wrap_size_in;
        end
        if (param_load_in) begin
            next_r.dummy_sel = dummy_sel_in;
        end

        if (r.cs_s2) begin
            next_r.st         = ST_IDLE;
            next_r.io_drive_n = 4'hf;
        end else begin
            case (r.st)
                ST_IDLE: begin
                    next_r.cnt = 5'h00;
                    next_r.sin = '0;
                    if (r.cont_quad &&
                        (quad_lane_enable_bit_in || four_line_command_mode)) begin
                        next_r.op = OP_QUAD_IO;
                        next_r.st = ST_ADDR;
                    end else if (r.cont_dual && !four_line_command_mode) begin
                        next_r.op = OP_DUAL_IO;
                        next_r.st = ST_ADDR;
                    end else begin
                        next_r.st = ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (rise) begin
                        next_r.sin = shifted;
                        next_r.cnt = 5'(r.cnt + 5'h01);
                    end
                    if (pend) begin
                        next_r.cnt = 5'h00;
                        next_r.st  = ST_ADDR;
                        if (shifted[7:0] == OPC_DUAL_OUT && !four_line_command_mode) begin
                            next_r.op = OP_DUAL_OUT;
                        end else if (shifted[7:0] == OPC_QUAD_OUT &&
                                     !four_line_command_mode && quad_lane_enable_bit_in) begin
                            next_r.op = OP_QUAD_OUT;
                        end else if (shifted[7:0] == OPC_DUAL_IO && !four_line_command_mode) begin
                            next_r.op = OP_DUAL_IO;
                        end else if (shifted[7:0] == OPC_QUAD_IO &&
                                     (quad_lane_enable_bit_in || four_line_command_mode)) begin
                            next_r.op = OP_QUAD_IO;
                        end else begin
                            next_r.st = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        next_r.sin = shifted;
                        next_r.cnt = 5'(r.cnt + 5'h01);
                    end
                    if (pend) begin
                        next_r.cnt  = 5'h00;
                        next_r.addr = shifted;
                        next_r.st   = r.op[1] ? ST_MODE : ST_DUMMY;
                    end
                end
                ST_MODE: begin
                    if (rise) begin
                        next_r.sin = shifted;
                        next_r.cnt = 5'(r.cnt + 5'h01);
                    end
                    if (pend) begin
                        // Only the upper nibble is looked at
                        next_r.cont_dual = r.op == OP_DUAL_IO &&
                                           shifted[7:4] == CONT_KEY;
                        next_r.cont_quad = r.op == OP_QUAD_IO &&
                                           shifted[7:4] == CONT_KEY;
                        next_r.cnt   = 5'h00;
                        next_r.chunk = 3'h0;
                        next_r.st    = (dlen == 5'h00) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (rise) begin
                        next_r.cnt = 5'(r.cnt + 5'h01);
                    end
                    if (pend) begin
                        next_r.cnt   = 5'h00;
                        next_r.chunk = 3'h0;
                        next_r.st    = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (fall) begin
                        // Fresh byte at chunk 0, address moves on at once
                        if (r.chunk == 3'h0) begin
                            next_r.addr = addr_inc;
                            if (lanes == 3'h4) begin
                                next_r.io_out = mem_data_in[7:4];
                                next_r.sout   = {mem_data_in[3:0], 4'h0};
                            end else begin
                                next_r.io_out = {2'h0, mem_data_in[7:6]};
                                next_r.sout   = {mem_data_in[5:0], 2'h0};
                            end
                        end else if (lanes == 3'h4) begin
                            next_r.io_out = r.sout[7:4];
                            next_r.sout   = {r.sout[3:0], 4'h0};
                        end else begin
                            next_r.io_out = {2'h0, r.sout[7:6]};
                            next_r.sout   = {r.sout[5:0], 2'h0};
                        end
                        if (lanes == 3'h4) begin
                            next_r.io_drive_n = 4'h0;
                            next_r.chunk = (r.chunk == 3'h1) ? 3'h0 : 3'h1;
                        end else begin
                            next_r.io_drive_n = 4'hc;
                            next_r.chunk = (r.chunk == 3'h3) ? 3'h0 :
                                           3'(r.chunk + 3'h1);
                        end
                    end
                end
                ST_IGNORE: begin
                    next_r.io_drive_n = 4'hf;
                end
                default: begin
                    next_r.st = ST_IDLE;
                end
            endcase
        end

        // Mode reset and reset command drop the latched key
        if (mode_reset_in || soft_reset_in) begin
            next_r.cont_dual = 1'b0;
            next_r.cont_quad = 1'b0;
        end
        if (soft_reset_in) begin
            next_r.dummy_sel = DUMMY_SEL_RST;
        end

        if (sys_rst_in) begin
            next_r            = '0;
            next_r.sck_s1     = 1'b0;
            next_r.cs_s1      = 1'b1;
            next_r.cs_s2      = 1'b1;
            next_r.st         = ST_IDLE;
            next_r.wrap_size  = WRAP_SIZE_RST;
            next_r.dummy_sel  = DUMMY_SEL_RST;
            next_r.io_drive_n = 4'hf;
        end
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        r <= next_r;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign io_lane_out    = r.io_out;
    assign io_drive_n_out = r.io_drive_n;
    assign mem_addr_out   = r.addr;
    assign dual_cont_out  = r.cont_dual;
    assign quad_cont_out  = r.cont_quad;
    assign wrap_on_out    = r.wrap_on;
    assign dummy_sel_out  = r.dummy_sel;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    logic cmd_done;
    logic mode_done;
    logic byte_load;
    assign cmd_done  = r.st == ST_CMD && pend && !r.cs_s2;
    assign mode_done = r.st == ST_MODE && pend && !r.cs_s2;
    assign byte_load = r.st == ST_DATA && fall && r.chunk == 3'h0;

    dual_out_lanes_a: assert property (
        r.st == ST_DATA && r.op == OP_DUAL_OUT && !r.io_drive_n[0]
        |-> r.io_drive_n == 4'hc)
        else $error("dual output drives wrong lanes");
    quad_out_lanes_a: assert property (
        byte_load && r.op == OP_QUAD_OUT |=> r.io_drive_n == 4'h0)
        else $error("quad output not on four lanes");
    quad_gate_a: assert property (
        cmd_done && shifted[7:0] == OPC_QUAD_OUT && !four_line_command_mode &&
        !quad_lane_enable_bit_in |=> r.st == ST_IGNORE)
        else $error("quad output taken without enable");
    drive_only_data_a: assert property (
        r.st != ST_DATA |-> r.io_drive_n == 4'hf)
        else $error("lanes driven outside data phase");
    dual_key_a: assert property (
        mode_done && r.op == OP_DUAL_IO && shifted[7:4] == CONT_KEY &&
        !mode_reset_in && !soft_reset_in |=> r.cont_dual)
        else $error("dual continuous key not latched");
    key_clear_a: assert property (
        mode_done && shifted[7:4] != CONT_KEY
        |=> !r.cont_dual && !r.cont_quad)
        else $error("continuous state kept on other key");
    quad_skip_a: assert property (
        r.st == ST_IDLE && !r.cs_s2 && r.cont_quad &&
        quad_lane_enable_bit_in |=> r.st == ST_ADDR && r.op == OP_QUAD_IO)
        else $error("opcode not skipped in quad continuous");
    wrap_bound_a: assert property (
        byte_load && wrap_act |=> r.addr[ADDR_W-1:6] == $past(r.addr[ADDR_W-1:6]))
        else $error("wrapped read left its section");
    seq_incr_a: assert property (
        byte_load && !wrap_act |=> r.addr == ADDR_W'($past(r.addr) + 1'b1))
        else $error("address not incremented");
    dummy_default_a: assert property (
        soft_reset_in |=> r.dummy_sel == DUMMY_SEL_RST)
        else $error("dummy count not defaulted");
    mode_reset_a: assert property (
        mode_reset_in |=> !r.cont_dual && !r.cont_quad)
        else $error("mode reset left continuous state");

    dual_read_c: cover property (mode_done && r.op == OP_DUAL_IO);
    quad_cont_c: cover property (r.st == ST_IDLE && !r.cs_s2 && r.cont_quad);
    wrap_read_c: cover property (byte_load && wrap_act);
    qpi_read_c:  cover property (byte_load && four_line_command_mode);

endmodule

// ==== include/fmrp_pkg.sv ====
package fmrp_pkg;

    // ------------------------------------------------------------
    // Opcodes and mode key
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_DUAL_OUT  = 8'h3b;
    localparam logic [7:0] OPC_QUAD_OUT  = 8'h6b;
    localparam logic [7:0] OPC_DUAL_IO   = 8'hbb;
    localparam logic [7:0] OPC_QUAD_IO   = 8'heb;
    localparam logic [3:0] CONT_KEY      = 4'ha;

    // ------------------------------------------------------------
    // Phase lengths in serial clocks
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_CLKS_1    = 5'h08;
    localparam logic [4:0] CMD_CLKS_4    = 5'h02;
    localparam logic [4:0] OUT_DUMMY     = 5'h08;
    localparam logic [4:0] DUAL_MODE     = 5'h04;
    localparam logic [4:0] QUAD_MODE     = 5'h02;
    localparam logic [4:0] QUAD_DUMMY    = 5'h04;
    localparam logic [4:0] QPI_DUMMY_4   = 5'h04;
    localparam logic [4:0] QPI_DUMMY_6   = 5'h06;
    localparam logic [4:0] QPI_DUMMY_8   = 5'h08;

    // ------------------------------------------------------------
    // Reset values and wrap masks
    // ------------------------------------------------------------
    localparam logic [1:0] DUMMY_SEL_RST = 2'h0;
    localparam logic [1:0] WRAP_SIZE_RST = 2'h0;
    localparam logic [7:0] WRAP_MASK_8   = 8'h07;
    localparam logic [7:0] WRAP_MASK_16  = 8'h0f;
    localparam logic [7:0] WRAP_MASK_32  = 8'h1f;
    localparam logic [7:0] WRAP_MASK_64  = 8'h3f;

    // ------------------------------------------------------------
    // State and operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_MODE   = 3'b011,
        ST_DUMMY  = 3'b100,
        ST_DATA   = 3'b101,
        ST_IGNORE = 3'b110
    } fmrp_state_type;

    typedef enum logic [1:0] {
        OP_DUAL_OUT = 2'b00,
        OP_QUAD_OUT = 2'b01,
        OP_DUAL_IO  = 2'b10,
        OP_QUAD_IO  = 2'b11
    } fmrp_op_type;

endpackage

// ==== tb/fmrp_host.sv ====
module fmrp_host (
    input  wire logic       ref_clk_in,
    input  wire logic [3:0] io_lane_in,
    input  wire logic [3:0] io_drive_n_in,
    output logic            sck_out,
    output logic            cs_n_out,
    output logic      [3:0] lane_out,
    output logic      [3:0] lane_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [0:79];
    logic [7:0] b;
    logic [3:0] drv;

    // Idle: select high, clock low, lanes released
    initial {sck_out, cs_n_out, lane_out, lane_oe_out} = 10'h100;

    // Shift n clocks on w lanes, MSB first; rl releases late in the high phase
    task automatic shift(input logic [31:0] v, input int n, w, input bit rl);
        for (int i = 0; i < n; i++) begin
            lane_out <= 4'(v >> ((n - 1 - i) * w));
            lane_oe_out <= 4'((1 << w) - 1);
            repeat (4) @(posedge ref_clk_in);
            sck_out <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            if (rl && i == n - 1)
                lane_oe_out <= 4'h0;
            @(posedge ref_clk_in);
            sck_out <= 1'b0;
        end
    endtask

    // One read frame in clock mode 0; ow of 0 leaves the opcode out
    task automatic xfer(input logic [7:0] op, input int ow,
                        input logic [23:0] a, input int aw, input bit hm,
                        input logic [7:0] md, input int dm, dw, n);
        @(posedge ref_clk_in);
        cs_n_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        if (ow != 0)
            shift(op, 8 / ow, ow, 1'b0);
        shift(a, 24 / aw, aw, !hm && dm == 0);
        if (hm)
            shift(md, 8 / aw, aw, dm == 0);
        shift(32'h0, dm, aw, 1'b1);
        for (int k = 0; k < n; k++) begin
            for (int j = 0; j < 8 / dw; j++) begin
                repeat (4) @(posedge ref_clk_in);
                b = (b << dw) | 8'(io_lane_in & 4'((1 << dw) - 1));
                drv = io_drive_n_in;
                sck_out <= 1'b1;
                repeat (4) @(posedge ref_clk_in);
                sck_out <= 1'b0;
            end
            got[k] = b;
        end
        repeat (4) @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
    endtask
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fmrp_pkg::*;

    logic        ref_clk_in, sys_rst_in, tick, qe, flm, mode_rst, kq;
    logic        wrap_load, wrap_on, param_load, soft_rst, sck, cs_n;
    logic        dual_cont, quad_cont, wrap_on_o;
    logic [1:0]  wrap_size, dsel, dsel_o;
    logic [3:0]  io_lane, io_out, io_drive_n, hout, hoe;
    logic [7:0]  md, mem_data;
    logic [23:0] mem_addr, m;
    int          errors, tests_run, seed, dn;

    fmrp_read_path #(.ADDR_W(24)) DUT (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck),
        .cs_n_in(cs_n), .io_lane_in(io_lane), .io_lane_out(io_out),
        .io_drive_n_out(io_drive_n), .quad_lane_enable_bit_in(qe),
        .four_line_command_mode_in(flm), .wrap_load_in(wrap_load),
        .wrap_on_in(wrap_on), .wrap_size_in(wrap_size),
        .param_load_in(param_load), .dummy_sel_in(dsel),
        .soft_reset_in(soft_rst), .mode_reset_in(mode_rst),
        .mem_addr_out(mem_addr), .mem_data_in(mem_data),
        .dual_cont_out(dual_cont), .quad_cont_out(quad_cont),
        .wrap_on_out(wrap_on_o), .dummy_sel_out(dsel_o));

    fmrp_host host (
        .ref_clk_in(ref_clk_in), .io_lane_in(io_lane),
        .io_drive_n_in(io_drive_n), .sck_out(sck), .cs_n_out(cs_n),
        .lane_out(hout), .lane_oe_out(hoe));

    // Lane level; a lane nobody drives toggles every cycle
    assign io_lane = (~io_drive_n & io_out) | (io_drive_n & hoe & hout)
                   | (io_drive_n & ~hoe & (hout ^ {4{tick}}));
    assign mem_data = mb(mem_addr);

    // Memory contents as a function of the address
    function automatic logic [7:0] mb(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ {a[19:16], a[23:20]};
    endfunction

    // System clock
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    // Float pattern; no lane may be driven from both ends
    always @(posedge ref_clk_in) begin
        tick <= ~tick;
        if (!sys_rst_in)
            check({4'h0, ~io_drive_n & hoe}, 8'h0, "contention");
    end

    // Compare one value
    task automatic check(input logic [7:0] g, e, input string s);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask

    // One-cycle strobe: 0 wrap, 1 read parameters, 2 soft reset, 3 mode reset
    task automatic cfg(input int k);
        @(posedge ref_clk_in);
        {wrap_load, param_load, soft_rst, mode_rst} <= 4'(8 >> k);
        @(posedge ref_clk_in);
        {wrap_load, param_load, soft_rst, mode_rst} <= 4'h0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    // One frame at a random address; wm masks the wrapping bits
    task automatic rd(input logic [7:0] op, input int ow, aw, input bit hm,
                      input logic [7:0] mo, input int dm, dw, n,
                      input logic [23:0] wm, input logic [3:0] ed);
        logic [23:0] a;
        a = 24'($random(seed));
        host.xfer(op, ow, a, aw, hm, mo, dm, dw, n);
        check({4'h0, host.drv}, {4'h0, ed}, "drive");
        for (int k = 0; k < n && ed != 4'hf; k++)
            check(host.got[k], mb((a & ~wm) | ((a + 24'(k)) & wm)), "data");
    endtask

    // Print counts and verdict, then stop
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Cut a hung run short
    initial begin
        repeat (90000) @(posedge ref_clk_in);
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish;
    end

    // Main sequence
    initial begin
        seed = 32'he50de9b0;
        {errors, tests_run} = 0;
        {sys_rst_in, tick, qe, flm, wrap_on, wrap_size, dsel} = 9'h100;
        {wrap_load, param_load, soft_rst, mode_rst, kq} = 5'h0;
        repeat (8) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        check({6'h0, dsel_o}, 8'h0, "dummy reset");
        rd(OPC_DUAL_OUT, 1, 1, 0, 8'h0, 8, 2, 5, '1, 4'hc);
        rd(OPC_QUAD_OUT, 1, 1, 0, 8'h0, 8, 4, 2, '1, 4'hf);
        qe <= 1'b1;
        rd(OPC_QUAD_OUT, 1, 1, 0, 8'h0, 8, 4, 3, '1, 4'h0);
        rd(OPC_DUAL_IO, 1, 2, 1, 8'ha3, 0, 2, 3, '1, 4'hc);
        rd(OPC_DUAL_IO, 0, 2, 1, 8'h5a, 0, 2, 3, '1, 4'hc);
        rd(OPC_DUAL_IO, 1, 2, 1, 8'h0, 0, 2, 3, '1, 4'hc);
        check({7'h0, dual_cont}, 8'h0, "dual key");
        repeat (8) begin
            md = 8'($random(seed));
            md[7:4] = md[0] ? CONT_KEY : md[7:4];
            rd(OPC_QUAD_IO, kq ? 0 : 1, 4, 1, md, 4, 4, 3, '1, 4'h0);
            kq = (md[7:4] == CONT_KEY);
            check({7'h0, quad_cont}, {7'h0, kq}, "quad key");
        end
        rd(OPC_QUAD_IO, kq ? 0 : 1, 4, 1, 8'ha0, 4, 4, 2, '1, 4'h0);
        cfg(3);
        check({7'h0, quad_cont}, 8'h0, "mode reset");
        rd(OPC_QUAD_IO, 1, 4, 1, 8'h0, 4, 4, 2, '1, 4'h0);
        qe <= 1'b0;
        rd(OPC_QUAD_IO, 1, 4, 1, 8'h0, 4, 4, 1, '1, 4'hf);
        qe <= 1'b1;
        wrap_on <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wrap_size <= 2'(s);
            cfg(0);
            m = 24'((8 << s) - 1);
            rd(OPC_QUAD_IO, 1, 4, 1, 8'h0, 4, 4, m + 3, m, 4'h0);
        end
        wrap_size <= 2'h0;
        cfg(0);
        flm <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            dsel <= 2'(s);
            cfg(1);
            check({6'h0, dsel_o}, 8'(s), "dummy sel");
            dn = (s == 0) ? 2 : (s == 1) ? 4 : 6;
            rd(OPC_QUAD_IO, 4, 4, 1, 8'h0, dn, 4, 11, '1, 4'h0);
        end
        cfg(2);
        check({6'h0, dsel_o}, 8'h0, "soft reset");
        check({7'h0, wrap_on_o}, 8'h1, "wrap kept");
        tally_and_finish;
    end
endmodule
